// File: core/oam_mon_pkg.sv
// constants, register map and defaults of the link OAM event monitor
package oam_mon_pkg;
  // time base
  localparam int TICK_MS   = 100;
  localparam int CLK_NS    = 5;
  localparam int TICK_CYC_DEF = TICK_MS * 1000000 / CLK_NS;
  localparam int SEC_TICKS = 10;

  // event index in fire, status and mask vectors
  localparam int EV_FE = 0;
  localparam int EV_FP = 1;
  localparam int EV_SP = 2;
  localparam int EV_ES = 3;
  localparam int EV_N  = 4;

  // control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_CLR_BIT = 1;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_INT_STAT  = 8'h04;
  localparam logic [7:0] OFF_INT_MASK  = 8'h08;
  localparam logic [7:0] OFF_SEQ       = 8'h0C;
  localparam logic [7:0] OFF_FE_WIN    = 8'h10;
  localparam logic [7:0] OFF_FE_THR    = 8'h14;
  localparam logic [7:0] OFF_FP_WIN    = 8'h18;
  localparam logic [7:0] OFF_FP_THR    = 8'h1C;
  localparam logic [7:0] OFF_SP_WIN_LO = 8'h20;
  localparam logic [7:0] OFF_SP_WIN_HI = 8'h24;
  localparam logic [7:0] OFF_SP_THR_LO = 8'h28;
  localparam logic [7:0] OFF_SP_THR_HI = 8'h2C;
  localparam logic [7:0] OFF_ES_WIN    = 8'h30;
  localparam logic [7:0] OFF_ES_THR    = 8'h34;
  localparam logic [7:0] OFF_FE_TS     = 8'h40;
  localparam logic [7:0] OFF_FE_CNT    = 8'h44;
  localparam logic [7:0] OFF_FE_TOT_LO = 8'h48;
  localparam logic [7:0] OFF_FE_TOT_HI = 8'h4C;
  localparam logic [7:0] OFF_FE_EVT    = 8'h50;
  localparam logic [7:0] OFF_FP_TS     = 8'h54;
  localparam logic [7:0] OFF_FP_CNT    = 8'h58;
  localparam logic [7:0] OFF_FP_TOT_LO = 8'h5C;
  localparam logic [7:0] OFF_FP_TOT_HI = 8'h60;
  localparam logic [7:0] OFF_FP_EVT    = 8'h64;
  localparam logic [7:0] OFF_SP_TS     = 8'h68;
  localparam logic [7:0] OFF_SP_CNT_LO = 8'h6C;
  localparam logic [7:0] OFF_SP_CNT_HI = 8'h70;
  localparam logic [7:0] OFF_SP_TOT_LO = 8'h74;
  localparam logic [7:0] OFF_SP_TOT_HI = 8'h78;
  localparam logic [7:0] OFF_SP_EVT    = 8'h7C;
  localparam logic [7:0] OFF_ES_TS     = 8'h80;
  localparam logic [7:0] OFF_ES_CNT    = 8'h84;
  localparam logic [7:0] OFF_ES_TOT    = 8'h88;
  localparam logic [7:0] OFF_ES_EVT    = 8'h8C;

  // window limits and reset values, errored-frame and seconds windows in 100 ms units
  localparam logic [15:0] FE_WIN_MIN = 16'h000A;
  localparam logic [15:0] FE_WIN_MAX = 16'h0258;
  localparam logic [15:0] FE_WIN_DEF = 16'h000A;
  localparam logic [31:0] FE_THR_DEF = 32'h0000_0001;
  localparam logic [31:0] FP_WIN_DEF = 32'h0000_2710;
  localparam logic [31:0] FP_THR_DEF = 32'h0000_0001;
  localparam logic [63:0] SP_WIN_DEF = 64'h0000_0000_0098_9680;
  localparam logic [63:0] SP_THR_DEF = 64'h0000_0000_0000_0001;
  localparam logic [15:0] ES_WIN_DEF = 16'h0258;
  localparam logic [15:0] ES_THR_DEF = 16'h0001;
  localparam logic [EV_N-1:0] MASK_DEF = 4'h0;
endpackage

// File: core/oam_window_mon.sv
// one observation-window error monitor with running totals
module oam_window_mon
  import oam_mon_pkg::*;
#(
  parameter int WW = 16,  // window width
  parameter int CW = 32,  // period count and threshold width
  parameter int TW = 64,  // running total width
  parameter int EW = 32   // event counter width
) (
  input  wire logic          clk,   // clock
  input  wire logic          clr,   // sublayer reset, synchronous
  input  wire logic          adv,   // one window unit elapsed
  input  wire logic          inc,   // one error seen
  input  wire logic [WW-1:0] win,   // window length in units
  input  wire logic [CW-1:0] thr,   // event threshold
  output logic               fire,  // one-cycle event pulse
  output logic [CW-1:0]      last,  // count of last closed window
  output logic [TW-1:0]      total, // running error total
  output logic [EW-1:0]      evts   // events generated
);
  logic [WW-1:0] unit_ff;
  logic [CW-1:0] per_ff;
  logic [CW-1:0] last_ff;
  logic          fire_ff;
  logic [TW-1:0] total_ff;
  logic [EW-1:0] evts_ff;
  logic [CW-1:0] cnt_now;
  logic          win_end;

  // an error in the closing cycle still belongs to the closing window
  assign cnt_now = per_ff + CW'(inc);
  assign win_end = adv && ((unit_ff + WW'(1)) >= win);

  always_ff @(posedge clk) begin
    if (clr || win_end) begin
      unit_ff <= '0;
    end else if (adv) begin
      unit_ff <= unit_ff + WW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      per_ff  <= '0;
      last_ff <= '0;
      fire_ff <= 1'b0;
    end else if (win_end) begin
      per_ff  <= '0;
      last_ff <= cnt_now;
      fire_ff <= (cnt_now >= thr);
    end else begin
      per_ff  <= cnt_now;
      fire_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      total_ff <= '0;
    end else if (inc) begin
      total_ff <= total_ff + TW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      evts_ff <= '0;
    end else if (fire_ff) begin
      evts_ff <= evts_ff + EW'(1);
    end
  end

  assign fire  = fire_ff;
  assign last  = last_ff;
  assign total = total_ff;
  assign evts  = evts_ff;

  win_clear_a: assert property (@(posedge clk) disable iff (clr)
    win_end |=> per_ff == '0 && last_ff == $past(cnt_now))
    else $error("period count not closed at window end");
  fire_cause_a: assert property (@(posedge clk) disable iff (clr)
    fire_ff |-> $past(win_end) && $past(cnt_now) >= $past(thr))
    else $error("event without window end over threshold");
  evt_count_a: assert property (@(posedge clk) disable iff (clr)
    fire_ff ##1 !clr |-> evts_ff == $past(evts_ff) + EW'(1))
    else $error("event counter did not step");
  total_step_a: assert property (@(posedge clk) disable iff (clr)
    inc ##1 !clr |-> total_ff == $past(total_ff) + TW'(1))
    else $error("running total did not step");
endmodule

// File: core/link_oam_event_monitor.sv
// link OAM link-event monitor: four window monitors behind a register port
// Function
// - keep 16-bit sequence number counting all link events generated
// - stamp each event with 16-bit time in 100 ms units
// - errored-frame window 16 bits in 100 ms, default 1 s, 1 s to 60 s
// - errored-frame event when window count at or above 32-bit threshold
// - 64-bit errored-frame total, cleared only by sublayer reset
// - 32-bit count of errored-frame events since sublayer reset
// - frame-period window is 32-bit count of received frames
// - 32-bit frame-error count per period, event at or above threshold
// - 64-bit frame-period error total since sublayer reset
// - 32-bit count of frame-period events since sublayer reset
// - symbol-period window is 64-bit count of symbols
// - 64-bit symbol-error count per window, event at or above threshold
// - 64-bit symbol-error total, cleared only by sublayer reset
// - 32-bit count of symbol-period events since sublayer reset
// - seconds window 16 bits in 100 ms; 16-bit count and threshold
// - 32-bit errored-seconds total since sublayer reset
// - 32-bit count of seconds-summary events since sublayer reset
// - errored second is a one-second interval with a frame error
//
// Added by the designer: the strobed register port and the placing of the registers.
module link_oam_event_monitor
  import oam_mon_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC_DEF  // cycles per 100 ms unit
) (
  input  wire logic            clk,       // 200 MHz clock
  input  wire logic            rst,       // synchronous reset, active high
  input  wire logic            frame_rx,  // one frame received, pulse
  input  wire logic            frame_err, // frame had a MAC error, pulse
  input  wire logic            sym_rx,    // one symbol observed, pulse
  input  wire logic            sym_err,   // symbol error, pulse
  input  wire logic [7:0]      addr,      // register byte address
  input  wire logic [31:0]     wdata,     // write data
  input  wire logic            wr_en,     // write strobe
  input  wire logic            rd_en,     // read strobe
  output logic      [31:0]     rdata,     // read data, cycle after strobe
  output logic      [EV_N-1:0] tlv_req,   // event TLV request, pulse
  output logic      [15:0]     seq_num,   // event sequence number
  output logic                 irq        // interrupt, level
);
  logic [31:0]     tick_cnt_ff;
  logic            tick;
  logic [3:0]      sec_cnt_ff;
  logic            sec_end;
  logic            err_seen_ff;
  logic            es_inc;
  logic [15:0]     ts_ff;
  logic [15:0]     seq_ff;
  logic            en_ff;
  logic            clr;
  logic [EV_N-1:0] stat_ff;
  logic [EV_N-1:0] mask_ff;
  logic [EV_N-1:0] fire;
  logic [31:0]     rdata_ff;
  logic [31:0]     rd_mux;
  logic [15:0]     fe_win_ff;
  logic [15:0]     nxt_fe_win;
  logic [31:0]     fe_thr_ff;
  logic [31:0]     fp_win_ff;
  logic [31:0]     fp_thr_ff;
  logic [63:0]     sp_win_ff;
  logic [63:0]     sp_thr_ff;
  logic [15:0]     es_win_ff;
  logic [15:0]     es_thr_ff;
  logic [15:0]     fe_ts_ff;
  logic [15:0]     fp_ts_ff;
  logic [15:0]     sp_ts_ff;
  logic [15:0]     es_ts_ff;
  logic [31:0]     fe_cnt;
  logic [63:0]     fe_tot;
  logic [31:0]     fe_evt;
  logic [31:0]     fp_cnt;
  logic [63:0]     fp_tot;
  logic [31:0]     fp_evt;
  logic [63:0]     sp_cnt;
  logic [63:0]     sp_tot;
  logic [31:0]     sp_evt;
  logic [15:0]     es_cnt;
  logic [31:0]     es_tot;
  logic [31:0]     es_evt;
  logic            wr_ctrl;

  assign wr_ctrl = wr_en && (addr == OFF_CTRL);
  // totals and event counters clear only on this sublayer reset
  assign clr = rst || (wr_ctrl && wdata[CTRL_CLR_BIT]);

  // 100 ms time base
  assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst || tick) begin
      tick_cnt_ff <= 32'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      ts_ff <= 16'h0;
    end else if (tick) begin
      ts_ff <= ts_ff + 16'h1;
    end
  end

  // one-second intervals for the errored-seconds monitor
  assign sec_end = tick && (sec_cnt_ff == 4'(SEC_TICKS - 1));

  always_ff @(posedge clk) begin
    if (clr || sec_end) begin
      sec_cnt_ff <= 4'h0;
    end else if (tick) begin
      sec_cnt_ff <= sec_cnt_ff + 4'h1;
    end
  end

  // an error in the closing cycle still marks the closing second
  assign es_inc = sec_end && en_ff && (err_seen_ff || frame_err);

  always_ff @(posedge clk) begin
    if (clr || sec_end) begin
      err_seen_ff <= 1'b0;
    end else if (frame_err && en_ff) begin
      err_seen_ff <= 1'b1;
    end
  end

  // the four monitors
  oam_window_mon #(.WW(16), .CW(32), .TW(64), .EW(32)) fe_mon (
    .clk   (clk),
    .clr   (clr),
    .adv   (tick && en_ff),
    .inc   (frame_err && en_ff),
    .win   (fe_win_ff),
    .thr   (fe_thr_ff),
    .fire  (fire[EV_FE]),
    .last  (fe_cnt),
    .total (fe_tot),
    .evts  (fe_evt)
  );

  oam_window_mon #(.WW(32), .CW(32), .TW(64), .EW(32)) fp_mon (
    .clk   (clk),
    .clr   (clr),
    .adv   (frame_rx && en_ff),
    .inc   (frame_err && en_ff),
    .win   (fp_win_ff),
    .thr   (fp_thr_ff),
    .fire  (fire[EV_FP]),
    .last  (fp_cnt),
    .total (fp_tot),
    .evts  (fp_evt)
  );

  oam_window_mon #(.WW(64), .CW(64), .TW(64), .EW(32)) sp_mon (
    .clk   (clk),
    .clr   (clr),
    .adv   (sym_rx && en_ff),
    .inc   (sym_err && en_ff),
    .win   (sp_win_ff),
    .thr   (sp_thr_ff),
    .fire  (fire[EV_SP]),
    .last  (sp_cnt),
    .total (sp_tot),
    .evts  (sp_evt)
  );

  oam_window_mon #(.WW(16), .CW(16), .TW(32), .EW(32)) es_mon (
    .clk   (clk),
    .clr   (clr),
    .adv   (tick && en_ff),
    .inc   (es_inc),
    .win   (es_win_ff),
    .thr   (es_thr_ff),
    .fire  (fire[EV_ES]),
    .last  (es_cnt),
    .total (es_tot),
    .evts  (es_evt)
  );

  // sequence number steps once per event; events may coincide
  always_ff @(posedge clk) begin
    if (clr) begin
      seq_ff <= 16'h0;
    end else begin
      seq_ff <= seq_ff + 16'(fire[0]) + 16'(fire[1])
                + 16'(fire[2]) + 16'(fire[3]);
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      fe_ts_ff <= 16'h0;
      fp_ts_ff <= 16'h0;
      sp_ts_ff <= 16'h0;
      es_ts_ff <= 16'h0;
    end else begin
      if (fire[EV_FE]) fe_ts_ff <= ts_ff;
      if (fire[EV_FP]) fp_ts_ff <= ts_ff;
      if (fire[EV_SP]) sp_ts_ff <= ts_ff;
      if (fire[EV_ES]) es_ts_ff <= ts_ff;
    end
  end

  // out-of-range errored-frame window writes are pulled to the nearest bound; other windows take wdata as written
  always_comb begin
    if (wdata[15:0] < FE_WIN_MIN) begin
      nxt_fe_win = FE_WIN_MIN;
    end else if (wdata[15:0] > FE_WIN_MAX) begin
      nxt_fe_win = FE_WIN_MAX;
    end else begin
      nxt_fe_win = wdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_ff <= 1'b1;
    end else if (wr_ctrl) begin
      en_ff <= wdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fe_win_ff <= FE_WIN_DEF;
      fe_thr_ff <= FE_THR_DEF;
      fp_win_ff <= FP_WIN_DEF;
      fp_thr_ff <= FP_THR_DEF;
      sp_win_ff <= SP_WIN_DEF;
      sp_thr_ff <= SP_THR_DEF;
      es_win_ff <= ES_WIN_DEF;
      es_thr_ff <= ES_THR_DEF;
      mask_ff   <= MASK_DEF;
    end else if (wr_en) begin
      case (addr)
        OFF_FE_WIN:    fe_win_ff <= nxt_fe_win;
        OFF_FE_THR:    fe_thr_ff <= wdata;
        OFF_FP_WIN:    fp_win_ff <= wdata;
        OFF_FP_THR:    fp_thr_ff <= wdata;
        OFF_SP_WIN_LO: sp_win_ff[31:0] <= wdata;
        OFF_SP_WIN_HI: sp_win_ff[63:32] <= wdata;
        OFF_SP_THR_LO: sp_thr_ff[31:0] <= wdata;
        OFF_SP_THR_HI: sp_thr_ff[63:32] <= wdata;
        OFF_ES_WIN:    es_win_ff <= wdata[15:0];
        OFF_ES_THR:    es_thr_ff <= wdata[15:0];
        OFF_INT_MASK:  mask_ff <= wdata[EV_N-1:0];
        default:       ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= '0;
    end else if (wr_en && (addr == OFF_INT_STAT)) begin
      stat_ff <= (stat_ff & ~wdata[EV_N-1:0]) | fire;
    end else begin
      stat_ff <= stat_ff | fire;
    end
  end

  always_comb begin
    case (addr)
      OFF_CTRL:      rd_mux = {31'h0, en_ff};
      OFF_INT_STAT:  rd_mux = {28'h0, stat_ff};
      OFF_INT_MASK:  rd_mux = {28'h0, mask_ff};
      OFF_SEQ:       rd_mux = {16'h0, seq_ff};
      OFF_FE_WIN:    rd_mux = {16'h0, fe_win_ff};
      OFF_FE_THR:    rd_mux = fe_thr_ff;
      OFF_FP_WIN:    rd_mux = fp_win_ff;
      OFF_FP_THR:    rd_mux = fp_thr_ff;
      OFF_SP_WIN_LO: rd_mux = sp_win_ff[31:0];
      OFF_SP_WIN_HI: rd_mux = sp_win_ff[63:32];
      OFF_SP_THR_LO: rd_mux = sp_thr_ff[31:0];
      OFF_SP_THR_HI: rd_mux = sp_thr_ff[63:32];
      OFF_ES_WIN:    rd_mux = {16'h0, es_win_ff};
      OFF_ES_THR:    rd_mux = {16'h0, es_thr_ff};
      OFF_FE_TS:     rd_mux = {16'h0, fe_ts_ff};
      OFF_FE_CNT:    rd_mux = fe_cnt;
      OFF_FE_TOT_LO: rd_mux = fe_tot[31:0];
      OFF_FE_TOT_HI: rd_mux = fe_tot[63:32];
      OFF_FE_EVT:    rd_mux = fe_evt;
      OFF_FP_TS:     rd_mux = {16'h0, fp_ts_ff};
      OFF_FP_CNT:    rd_mux = fp_cnt;
      OFF_FP_TOT_LO: rd_mux = fp_tot[31:0];
      OFF_FP_TOT_HI: rd_mux = fp_tot[63:32];
      OFF_FP_EVT:    rd_mux = fp_evt;
      OFF_SP_TS:     rd_mux = {16'h0, sp_ts_ff};
      OFF_SP_CNT_LO: rd_mux = sp_cnt[31:0];
      OFF_SP_CNT_HI: rd_mux = sp_cnt[63:32];
      OFF_SP_TOT_LO: rd_mux = sp_tot[31:0];
      OFF_SP_TOT_HI: rd_mux = sp_tot[63:32];
      OFF_SP_EVT:    rd_mux = sp_evt;
      OFF_ES_TS:     rd_mux = {16'h0, es_ts_ff};
      OFF_ES_CNT:    rd_mux = {16'h0, es_cnt};
      OFF_ES_TOT:    rd_mux = es_tot;
      OFF_ES_EVT:    rd_mux = es_evt;
      default:       rd_mux = 32'h0;
    endcase
  end

  // data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst || !rd_en) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= rd_mux;
    end
  end

  assign rdata   = rdata_ff;
  assign tlv_req = fire;
  assign seq_num = seq_ff;
  assign irq     = |(stat_ff & mask_ff);

  fe_clamp_a: assert property (@(posedge clk) disable iff (rst)
    fe_win_ff >= FE_WIN_MIN && fe_win_ff <= FE_WIN_MAX)
    else $error("frame error window out of bounds");
  seq_step_a: assert property (@(posedge clk) disable iff (clr)
    fire == 4'h1 ##1 !clr |-> seq_ff == $past(seq_ff) + 16'h1)
    else $error("sequence number did not step once");
  ts_capture_a: assert property (@(posedge clk) disable iff (clr)
    fire[EV_FE] ##1 !clr |-> fe_ts_ff == $past(ts_ff))
    else $error("event timestamp not captured");
  ts_step_a: assert property (@(posedge clk) disable iff (clr)
    tick ##1 !clr |-> ts_ff == $past(ts_ff) + 16'h1)
    else $error("time base did not advance");
  stat_sticky_a: assert property (@(posedge clk) disable iff (rst)
    stat_ff[EV_FE] && !(wr_en && addr == OFF_INT_STAT) |=> stat_ff[EV_FE])
    else $error("status bit lost without clear");
  irq_follow_a: assert property (@(posedge clk) disable iff (rst)
    fire[EV_ES] && mask_ff[EV_ES] |=> irq)
    else $error("masked-in event gave no interrupt");
  rd_once_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  es_mark_a: assert property (@(posedge clk) disable iff (clr)
    sec_end && en_ff && (err_seen_ff || frame_err) ##1 !clr
    |-> es_tot == $past(es_tot) + 32'h1)
    else $error("errored second not counted");
endmodule

// File: tb/oam_link_peer.sv
// link-side model: frames and symbols toward the monitor, counts TLV requests
module oam_link_peer
  import oam_mon_pkg::*;
(
  input  wire logic            clk,       // clock
  input  wire logic [EV_N-1:0] tlv_req,   // event requests from the monitor
  output logic                 frame_rx,  // one frame received
  output logic                 frame_err, // that frame was errored
  output logic                 sym_rx,    // one symbol observed
  output logic                 sym_err    // that symbol was errored
);
  timeunit 1ns;
  timeprecision 1ps;

  int n_ev [EV_N];

  initial begin
    frame_rx  = 1'b0;
    frame_err = 1'b0;
    sym_rx    = 1'b0;
    sym_err   = 1'b0;
    n_ev      = '{default: 0};
  end

  // counted here so that a lost or doubled pulse shows at the far side
  always @(posedge clk) begin
    for (int b = 0; b < EV_N; b++) begin
      if (tlv_req[b] === 1'b1)
        n_ev[b]++;
    end
  end

  task automatic drive(input bit sel, input logic v, input logic er);
    if (sel) begin
      sym_rx  <= v;
      sym_err <= er;
    end else begin
      frame_rx  <= v;
      frame_err <= er;
    end
  endtask

  // sel 0 sends frames, 1 symbols; gap 0 keeps the units back to back
  task automatic send(input bit sel, input int n, input logic [31:0] e,
                      input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      drive(sel, 1'b1, e[i]);
      if (gap > 0) begin
        @(posedge clk);
        drive(sel, 1'b0, 1'b0);
        repeat (gap - 1) @(posedge clk);
      end
    end
    @(posedge clk);
    drive(sel, 1'b0, 1'b0);
  endtask
endmodule

// File: tb/link_oam_event_monitor_tb_top.sv
// self-checking bench of the link OAM event monitor
module link_oam_event_monitor_tb_top;
  import oam_mon_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk;
  logic            rst;
  logic [7:0]      addr;
  logic [31:0]     wdata;
  logic            wr_en;
  logic            rd_en;
  logic [31:0]     rdata;
  logic [EV_N-1:0] tlv_req;
  logic [15:0]     seq_num;
  logic            irq;
  logic            frame_rx;
  logic            frame_err;
  logic            sym_rx;
  logic            sym_err;
  int              err_total;
  int              checked;
  int              seed;

  // short time base keeps each 100 ms unit at 20 cycles
  link_oam_event_monitor #(.TICK_CYCLES(20)) uut (
    .clk(clk), .rst(rst), .frame_rx(frame_rx), .frame_err(frame_err),
    .sym_rx(sym_rx), .sym_err(sym_err), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tlv_req(tlv_req),
    .seq_num(seq_num), .irq(irq));

  oam_link_peer peer (
    .clk(clk), .tlv_req(tlv_req), .frame_rx(frame_rx),
    .frame_err(frame_err), .sym_rx(sym_rx), .sym_err(sym_err));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk({32'h0, d}, {32'h0, e});
  endtask

  task automatic rchk64(input logic [7:0] lo, input logic [7:0] hi,
                        input logic [63:0] e);
    logic [31:0] l;
    logic [31:0] h;
    rd(lo, l);
    rd(hi, h);
    chk({h, l}, e);
  endtask

  task automatic wait_ev(input int b, input int lim, output bit hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk);
      #1 hit = (tlv_req[b] === 1'b1);
    end
  endtask

  task automatic need_ev(input int b, input int lim);
    bit hit;
    wait_ev(b, lim, hit);
    chk(hit, 1'b1);
    if (!hit)
      finish_test();
  endtask

  logic [7:0]  da [10] = '{OFF_CTRL, OFF_INT_MASK, OFF_FE_WIN, OFF_FE_THR,
    OFF_FP_WIN, OFF_SP_WIN_LO, OFF_ES_WIN, OFF_ES_THR, OFF_SEQ, 8'hFC};
  logic [31:0] dv [10] = '{32'h1, 32'h0, 32'hA, 32'h1, 32'h2710,
    32'h0098_9680, 32'h258, 32'h1, 32'h0, 32'h0};

  initial begin
    logic [31:0] v;
    logic [31:0] e;
    logic [31:0] ts1;
    bit          hit;
    int          last;
    int          tot;
    int          ev;
    int          stot;
    int          sev;
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_total = 0;
    checked = 0;
    seed = 32'h17b8;
    tot = 0;
    ev = 0;
    stot = 0;
    sev = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped place, read data standing one cycle only
    for (int i = 0; i < 10; i++)
      rchk(da[i], dv[i]);
    @(posedge clk);
    #1 chk({32'h0, rdata}, 64'h0);
    wr(OFF_FE_WIN, 32'h5);
    rchk(OFF_FE_WIN, 32'hA);
    wr(OFF_FE_WIN, 32'h3E8);
    rchk(OFF_FE_WIN, 32'h258);
    wr(OFF_FE_WIN, 32'h1E);
    rchk(OFF_FE_WIN, 32'h1E);
    wr(OFF_FE_WIN, 32'hA);
    $display("test defaults done");
    // frame periods of four frames, back to back then spaced
    wr(OFF_FP_WIN, 32'h4);
    wr(OFF_FP_THR, 32'h2);
    e = $random(seed) | 32'h0000_000F;
    peer.send(0, 16, e, 0);
    peer.send(0, 16, e >> 16, 2);
    for (int w = 0; w < 8; w++) begin
      last = $countones(e[w*4 +: 4]);
      tot += last;
      if (last >= 2)
        ev++;
    end
    repeat (4) @(posedge clk);
    rchk(OFF_FP_CNT, last);
    rchk64(OFF_FP_TOT_LO, OFF_FP_TOT_HI, tot);
    rchk(OFF_FP_EVT, ev);
    chk(peer.n_ev[1], ev);
    // interrupt raised, masked and cleared
    // irq follows the mask register only after the write edge has settled
    wr(OFF_INT_MASK, 32'h2);
    #1 chk(irq, 1'b1);
    wr(OFF_INT_MASK, 32'h0);
    #1 chk(irq, 1'b0);
    rd(OFF_INT_STAT, v);
    chk(v[1], 1'b1);
    wr(OFF_INT_STAT, 32'h2);
    wr(OFF_INT_MASK, 32'h2);
    #1 chk(irq, 1'b0);
    rd(OFF_INT_STAT, v);
    chk(v[1], 1'b0);
    // disabled monitor ignores errors
    wr(OFF_CTRL, 32'h0);
    peer.send(0, 4, 32'hF, 0);
    wr(OFF_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    rchk64(OFF_FP_TOT_LO, OFF_FP_TOT_HI, tot);
    $display("test frame period done");
    // symbol windows of eight symbols, threshold three
    wr(OFF_SP_WIN_LO, 32'h8);
    wr(OFF_SP_WIN_HI, 32'h0);
    wr(OFF_SP_THR_LO, 32'h3);
    wr(OFF_SP_THR_HI, 32'h0);
    e = $random(seed);
    peer.send(1, 32, e, 1);
    for (int w = 0; w < 4; w++) begin
      last = $countones(e[w*8 +: 8]);
      stot += last;
      if (last >= 3)
        sev++;
    end
    repeat (4) @(posedge clk);
    rchk64(OFF_SP_CNT_LO, OFF_SP_CNT_HI, last);
    rchk64(OFF_SP_TOT_LO, OFF_SP_TOT_HI, stot);
    rchk(OFF_SP_EVT, sev);
    chk(peer.n_ev[2], sev);
    $display("test symbol period done");
    // sublayer reset clears totals, keeps configuration
    wr(OFF_ES_WIN, 32'h1E);
    wr(OFF_ES_THR, 32'h2);
    wr(OFF_FE_THR, 32'h0);
    wr(OFF_CTRL, 32'h3);
    peer.send(0, 1, 32'h1, 0);
    // only the one errored frame sent after the clear is in the total
    rchk64(OFF_FP_TOT_LO, OFF_FP_TOT_HI, 64'h1);
    rchk(OFF_SP_EVT, 32'h0);
    rchk(OFF_SP_WIN_LO, 32'h8);
    wr(OFF_FP_WIN, 32'h3E8);
    wr(OFF_INT_MASK, 32'h8);
    // errored-frame windows of ten units, aligned on the event pulse
    need_ev(EV_FE, 230);
    repeat (2) @(posedge clk);
    rchk(OFF_FE_CNT, 32'h1);
    rd(OFF_FE_TS, ts1);
    peer.send(0, 3, 32'h7, 0);
    need_ev(EV_FE, 230);
    repeat (2) @(posedge clk);
    rchk(OFF_FE_CNT, 32'h3);
    rchk64(OFF_FE_TOT_LO, OFF_FE_TOT_HI, 64'h4);
    rchk(OFF_FE_EVT, 32'h2);
    rd(OFF_FE_TS, v);
    chk(v - ts1, 32'hA);
    chk(irq, 1'b0);
    wr(OFF_FE_THR, 32'h4);
    // two errored seconds in a three-second window reach threshold two
    need_ev(EV_ES, 300);
    repeat (2) @(posedge clk);
    rchk(OFF_ES_CNT, 32'h2);
    rchk(OFF_ES_TOT, 32'h2);
    rchk(OFF_ES_EVT, 32'h1);
    chk(irq, 1'b1);
    peer.send(0, 4, 32'hF, 0);
    need_ev(EV_FE, 230);
    peer.send(0, 3, 32'h7, 0);
    wait_ev(EV_FE, 230, hit);
    chk(hit, 1'b0);
    rchk(OFF_FE_CNT, 32'h3);
    rchk(OFF_FE_EVT, 32'h3);
    chk(seq_num, 16'h4);
    rchk(OFF_SEQ, 32'h4);
    $display("test errored frame and seconds done");
    finish_test();
  end

  initial begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule
